// ### logic/e3oh_params.svh
// Purpose: Constants for the receive overhead serial output port.
// Assumes: Included by bare name from the design files.
// Notes:   Definitions only.
`ifndef E3OH_PARAMS_SVH
`define E3OH_PARAMS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define E3OH_FRAME_BITS  1536
`define E3OH_OH_BITS     12
`define E3OH_FIRST_IDX   4'h0
`define E3OH_A_IDX       4'hA
`define E3OH_LAST_IDX    4'hB
`define E3OH_WORD_MSB    4'hB

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define E3OH_WORD_RST    12'h000
`define E3OH_BIT_RST     1'h0

`endif

// ### logic/e3oh_pkg.sv
// Purpose: Types shared by the receive overhead serial output port.
// Assumes: Nothing beyond the parameter header.
// Notes:   Word bits 11..2 hold the alignment word 9..0, bit 1 A, bit 0 N.
package e3oh_pkg;

  typedef logic [11:0] e3oh_word_t;
  typedef logic [3:0]  e3oh_idx_t;

endpackage : e3oh_pkg

// ### logic/e3oh_sync_if.sv
// Purpose: Carries one level across from the core domain to the link domain.
// Assumes: The launching side drives async_lvl from a flip-flop.
// Notes:   sync_lvl is the level after two link-clock flip-flops.
`timescale 1ns/1ps
interface e3oh_sync_if;
  logic async_lvl;
  logic sync_lvl;

  modport launch  (output async_lvl, input  sync_lvl);
  modport capture (input  async_lvl, output sync_lvl);
endinterface : e3oh_sync_if

// ### logic/e3oh_sync2.sv
// Purpose: Two flip-flop level synchroniser into the link domain.
// Assumes: The source level is held for at least three link clocks.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module e3oh_sync2 (
  input  wire logic      dst_clk_in,
  input  wire logic      dst_rstn_in,
  e3oh_sync_if.capture   sync_port
);
  logic meta_q;
  logic stable_q;

  always_ff @(posedge dst_clk_in or negedge dst_rstn_in) begin
    if (!dst_rstn_in) begin
      meta_q   <= 1'h0;
      stable_q <= 1'h0;
    end else begin
      meta_q   <= sync_port.async_lvl;
      stable_q <= meta_q;
    end
  end

  assign sync_port.sync_lvl = stable_q;
endmodule : e3oh_sync2

// ### logic/e3oh_rx_oh_serial.sv
// Purpose: Serial output of the twelve overhead bits of each received frame.
// Assumes: Framer logic on core_clk_in presents each frame's overhead word
//          with a one-cycle valid, frames far apart compared to link clocks.
// Notes:   The overhead clock is the link clock divided by two.
`timescale 1ns/1ps
`include "e3oh_params.svh"
module e3oh_rx_oh_serial (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        link_clk_in,
  input  wire logic [11:0] overhead_word_in,
  input  wire logic        overhead_word_valid_in,
  output logic             overhead_data_out,
  output logic             overhead_clock_out,
  output logic             overhead_frame_start_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic oh_bit(input e3oh_pkg::e3oh_word_t word,
                                  input e3oh_pkg::e3oh_idx_t  idx);
    e3oh_pkg::e3oh_idx_t pos;
    pos    = `E3OH_WORD_MSB - idx;
    oh_bit = word[pos];
  endfunction : oh_bit

  // ----------------------------------------------------------------------
  // Core domain capture
  // ----------------------------------------------------------------------
  // The word register is only rewritten on a new valid, so it is stable
  // long before the link side samples it after the toggle crosses.
  e3oh_pkg::e3oh_word_t core_word_q;
  logic                 core_req_q;
  e3oh_sync_if          req_sync ();

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_word_q <= `E3OH_WORD_RST;
    end else if (overhead_word_valid_in) begin
      core_word_q <= overhead_word_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      core_req_q <= 1'h0;
    end else if (overhead_word_valid_in) begin
      core_req_q <= ~core_req_q;
    end
  end

  assign req_sync.async_lvl = core_req_q;

  // ----------------------------------------------------------------------
  // Link domain reset and crossing
  // ----------------------------------------------------------------------
  logic link_rst_meta_q;
  logic link_rstn_q;

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      link_rst_meta_q <= 1'h0;
      link_rstn_q     <= 1'h0;
    end else begin
      link_rst_meta_q <= 1'h1;
      link_rstn_q     <= link_rst_meta_q;
    end
  end

  e3oh_sync2 u_req_sync (
    .dst_clk_in  (link_clk_in),
    .dst_rstn_in (link_rstn_q),
    .sync_port   (req_sync)
  );

  logic                 req_seen_q;
  e3oh_pkg::e3oh_word_t pending_word_q;

  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      req_seen_q <= 1'h0;
    end else begin
      req_seen_q <= req_sync.sync_lvl;
    end
  end

  // A word that arrives mid-frame waits here for the next frame boundary.
  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      pending_word_q <= `E3OH_WORD_RST;
    end else if (req_sync.sync_lvl != req_seen_q) begin
      pending_word_q <= core_word_q;
    end
  end

  // ----------------------------------------------------------------------
  // Overhead clock and serialiser
  // ----------------------------------------------------------------------
  logic                 oh_clk_q;
  logic                 fall_edge;
  e3oh_pkg::e3oh_idx_t  bit_cnt_q;
  e3oh_pkg::e3oh_idx_t  bit_cnt_d;
  e3oh_pkg::e3oh_word_t cur_word_q;
  logic                 data_q;
  logic                 frame_q;

  // The clock free-runs from link reset release on; nothing gates it.
  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      oh_clk_q <= 1'h0;
    end else begin
      oh_clk_q <= ~oh_clk_q;
    end
  end

  // Data, marker and clock all leave flip-flops on the same link edge, so
  // data changes together with the overhead clock's fall.
  assign fall_edge = oh_clk_q;

  always_comb begin
    if (bit_cnt_q == `E3OH_LAST_IDX) begin
      bit_cnt_d = `E3OH_FIRST_IDX;
    end else begin
      bit_cnt_d = bit_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      bit_cnt_q <= `E3OH_LAST_IDX;
    end else if (fall_edge) begin
      bit_cnt_q <= bit_cnt_d;
    end
  end

  // Without a fresh word the previous frame's bits are repeated.
  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      cur_word_q <= `E3OH_WORD_RST;
    end else if (fall_edge && (bit_cnt_q == `E3OH_LAST_IDX)) begin
      cur_word_q <= pending_word_q;
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      data_q <= `E3OH_BIT_RST;
    end else if (fall_edge && (bit_cnt_q == `E3OH_LAST_IDX)) begin
      data_q <= oh_bit(pending_word_q, `E3OH_FIRST_IDX);
    end else if (fall_edge) begin
      data_q <= oh_bit(cur_word_q, bit_cnt_d);
    end
  end

  always_ff @(posedge link_clk_in or negedge link_rstn_q) begin
    if (!link_rstn_q) begin
      frame_q <= 1'h0;
    end else if (fall_edge) begin
      frame_q <= (bit_cnt_d == `E3OH_FIRST_IDX);
    end
  end

  assign overhead_data_out        = data_q;
  assign overhead_clock_out       = oh_clk_q;
  assign overhead_frame_start_out = frame_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence frame_marker_period;
    frame_q [*2] ##1 !frame_q;
  endsequence

  sequence next_frame_marker;
    ##24 $rose(frame_q);
  endsequence

  // The release edge and the edge after it still compare reset values, so the
  // toggle check only starts once the previous sample was out of reset.
  chk_clock_free_run: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $past(link_rstn_q) |-> (oh_clk_q != $past(oh_clk_q)))
    else $error("overhead clock stopped toggling");

  chk_data_on_fall: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $changed(data_q) |-> $fell(oh_clk_q))
    else $error("overhead data changed away from a falling clock edge");

  chk_marker_one_period: assert property (
    @(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> frame_marker_period)
    else $error("frame marker not high for exactly one overhead clock");

  chk_marker_spacing: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> next_frame_marker)
    else $error("frame markers not twelve overhead clocks apart");

  chk_marker_first_bit: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> (data_q == cur_word_q[11]) && (bit_cnt_q == `E3OH_FIRST_IDX))
    else $error("first alignment bit not under the frame marker");

  chk_align_second_bit: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> ##2 (data_q == cur_word_q[10]))
    else $error("alignment bit 8 not on the second overhead clock");

  chk_a_bit_slot: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> ##20 (data_q == cur_word_q[1]) && (bit_cnt_q == `E3OH_A_IDX))
    else $error("A bit not at count ten");

  chk_n_bit_slot: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    $rose(frame_q) |-> ##22 (data_q == cur_word_q[0]))
    else $error("N bit not at count eleven");

  chk_count_range: assert property (@(posedge link_clk_in) disable iff (!link_rstn_q)
    bit_cnt_q <= `E3OH_LAST_IDX)
    else $error("overhead bit counter out of range");

  chk_req_toggle: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    overhead_word_valid_in |=> $changed(core_req_q) && (core_word_q == $past(overhead_word_in)))
    else $error("overhead word not captured on valid");

endmodule : e3oh_rx_oh_serial

// ### sim/e3oh_te_model.sv
// Purpose: Terminal equipment model that rebuilds each frame's overhead word.
// Assumes: Samples only on the rising overhead clock edge.
// Notes:   gap_out is the number of rising edges between two frame markers.
`timescale 1ns/1ps
module e3oh_te_model (
  input  wire logic        oh_clk_in,
  input  wire logic        oh_data_in,
  input  wire logic        oh_frame_in,
  output logic [11:0]      word_out,
  output logic [3:0]       gap_out,
  output int               frames_out
);
  logic [11:0] shift_q;
  logic [3:0]  cnt_q;
  logic        seen_q;

  initial begin
    {shift_q, cnt_q, seen_q, word_out, gap_out} = '0;
    frames_out = 0;
  end

  // The count saturates so that a missing marker cannot wrap into a legal gap.
  always @(posedge oh_clk_in) begin
    shift_q <= {shift_q[10:0], oh_data_in};
    if (oh_frame_in) begin
      if (seen_q) gap_out <= cnt_q + 4'h1;
      cnt_q  <= 4'h0;
      seen_q <= 1'b1;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
    if (!oh_frame_in && seen_q && cnt_q == 4'hA) begin
      word_out   <= {shift_q[10:0], oh_data_in};
      frames_out <= frames_out + 1;
    end
  end
endmodule : e3oh_te_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the receive overhead serial output port.
// Assumes: Inputs change on the falling core clock edge.
// Notes:   The link clock is 12 ns with an unrelated phase.
`timescale 1ns/1ps
module tb_top;
  logic        core_clk_in, link_clk_in, rstn_in, valid, mon_on;
  logic [11:0] word, te_word;
  logic [3:0]  te_gap;
  logic        oh_data, oh_clk, oh_frame, prev_clk, prev_data;
  int          te_frames;
  int          bad_count = 0;
  int          cmp_count = 0;

  e3oh_rx_oh_serial uut (
    .core_clk_in              (core_clk_in),
    .rstn_in                  (rstn_in),
    .link_clk_in              (link_clk_in),
    .overhead_word_in         (word),
    .overhead_word_valid_in   (valid),
    .overhead_data_out        (oh_data),
    .overhead_clock_out       (oh_clk),
    .overhead_frame_start_out (oh_frame)
  );

  e3oh_te_model te (
    .oh_clk_in   (oh_clk),
    .oh_data_in  (oh_data),
    .oh_frame_in (oh_frame),
    .word_out    (te_word),
    .gap_out     (te_gap),
    .frames_out  (te_frames)
  );

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  initial begin
    link_clk_in = 1'b0;
    #3.7;
    forever #6 link_clk_in = ~link_clk_in;
  end

  task automatic chk_word(input string name, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string name, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %b got %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic end_sim();
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim

  // Sampling 1 ns after the link edge lets the registered outputs settle first.
  always @(posedge link_clk_in) begin
    #1;
    if (mon_on) begin
      chk_bit("clock toggles", ~prev_clk, oh_clk);
      if (oh_data !== prev_data) chk_bit("clock at data change", 1'b0, oh_clk);
      chk_bit("data driven", 1'b1, (oh_data === 1'b0) || (oh_data === 1'b1));
    end
    prev_clk  = oh_clk;
    prev_data = oh_data;
  end

  task automatic wait_frames(input int n);
    int start;
    start = te_frames;
    for (int i = 0; i < 3000 && te_frames < start + n; i++) @(negedge core_clk_in);
    chk_bit("frame progress", 1'b1, te_frames >= start + n);
  endtask : wait_frames

  task automatic do_reset();
    mon_on  = 1'b0;
    rstn_in = 1'b0;
    repeat (16) @(negedge core_clk_in);
    chk_bit("reset data", 1'b0, oh_data);
    chk_bit("reset clock", 1'b0, oh_clk);
    chk_bit("reset marker", 1'b0, oh_frame);
    rstn_in = 1'b1;
    repeat (8) @(negedge core_clk_in);
    mon_on = 1'b1;
  endtask : do_reset

  task automatic test_idle_word();
    wait_frames(3);
    chk_word("idle word", 12'h000, te_word);
    chk_word("edges per frame", 12'h00C, {8'h00, te_gap});
  endtask : test_idle_word

  task automatic test_words();
    logic [11:0] tbl[5] = '{12'h6E5, 12'h1A2, 12'hFFF, 12'h556, 12'h9B3};
    foreach (tbl[i]) begin
      @(negedge core_clk_in);
      word  = tbl[i];
      valid = 1'b1;
      @(negedge core_clk_in);
      valid = 1'b0;
      wait_frames(3);
      chk_word("frame word", tbl[i], te_word);
      chk_word("marker spacing", 12'h00C, {8'h00, te_gap});
    end
    wait_frames(2);
    chk_word("repeated word", 12'h9B3, te_word);
  endtask : test_words

  initial begin
    rstn_in   = 1'b0;
    valid     = 1'b0;
    word      = 12'h000;
    mon_on    = 1'b0;
    prev_clk  = 1'b0;
    prev_data = 1'b0;
    do_reset();
    test_idle_word();
    test_words();
    do_reset();
    test_idle_word();
    end_sim();
  end

  initial begin
    #200us;
    bad_count++;
    end_sim();
  end
endmodule : tb_top
